// *** include/spi_frame_if.sv ***
`timescale 1ns/1ps
interface spi_frame_if;
	logic [status_pkg::DATA_W-1:0] status_word;
	logic read_done;
	modport link (input status_word, output read_done);
	modport core (output status_word, input read_done);
endinterface

// *** include/status_pkg.sv ***
package status_pkg;
	// serial frame layout
	localparam int ADDR_W = 7;
	localparam int DATA_W = 24;
	localparam int IRQ_W = 16;
	localparam logic [5:0] CMD_LAST = 6'h07;
	localparam logic [5:0] DATA_FIRST = 6'h08;
	localparam logic [5:0] FRAME_LAST = 6'h1F;
	localparam logic [5:0] CNT_ZERO = 6'h00;
	localparam logic [5:0] CNT_ONE = 6'h01;
	// register addresses
	localparam logic [ADDR_W-1:0] NULL_LOW_ADDR = 7'h00;
	localparam logic [ADDR_W-1:0] STATUS_ADDR = 7'h01;
	localparam logic [ADDR_W-1:0] NULL_HIGH_ADDR = 7'h7F;
	// status bit positions
	localparam int DCLOFF_BIT = 20;
	localparam int FIFO_THR_BIT = 19;
	localparam int FIFO_OVF_BIT = 18;
	localparam int OVER_BIT = 17;
	localparam int UNDER_BIT = 16;
	localparam int DRV_MON_BIT = 15;
	localparam int LEADS_ON_BIT = 11;
	localparam int SYNC_BIT = 9;
	localparam int PLL_BIT = 8;
	localparam int IRQ_LSB = 8;
	localparam int DRV_POS_BIT = 5;
	localparam int DRV_NEG_BIT = 4;
	localparam int LDOFF_LSB = 0;
	localparam logic [DATA_W-1:0] FLAG_MASK = 24'h1F8B3F;
	localparam logic [DATA_W-1:0] STATUS_RESET = 24'h000000;
	// persistence times
	localparam int unsigned CLK_KHZ = 125000;
	localparam int unsigned DCLOFF_TIME_MS = 90;
	localparam int unsigned OVER_TIME_MS = 100;
	localparam int unsigned UNDER_TIME_MS = 1700; // 1.7 s
	localparam int unsigned DRIVE_TIME_MS = 128;
	localparam int unsigned DCLOFF_CYCLES = DCLOFF_TIME_MS * CLK_KHZ + 1; // strictly longer
	localparam int unsigned OVER_CYCLES = OVER_TIME_MS * CLK_KHZ;
	localparam int unsigned UNDER_CYCLES = UNDER_TIME_MS * CLK_KHZ;
	localparam int unsigned DRIVE_CYCLES = DRIVE_TIME_MS * CLK_KHZ;
	localparam int unsigned SYNC_HOLD_CYCLES = 1000;
	// sync pulse divider codes and terminal counts
	localparam logic [1:0] DIV_EVERY1 = 2'h0;
	localparam logic [1:0] DIV_EVERY2 = 2'h1;
	localparam logic [1:0] DIV_EVERY4 = 2'h2;
	localparam logic [3:0] LAST_EVERY1 = 4'h0;
	localparam logic [3:0] LAST_EVERY2 = 4'h1;
	localparam logic [3:0] LAST_EVERY4 = 4'h3;
	localparam logic [3:0] LAST_EVERY16 = 4'hF;
	localparam logic SYNC_SELF_CLEAR = 1'b1;
	// leads-on select codes that force the flag
	localparam logic [1:0] LEADSON_SEL_A = 2'h1;
	localparam logic [1:0] LEADSON_SEL_B = 2'h2;
	// link phase, gray coded
	typedef enum logic [1:0] {PH_CMD = 2'h0, PH_DATA = 2'h1, PH_DONE = 2'h3} phase_t;
endpackage

// *** rtl/spi_link.sv ***
`timescale 1ns/1ps
module spi_link
(
	input wire logic sclk,
	input wire logic rst,
	input wire logic csb_n,
	input wire logic sdi,
	output logic sdo,
	spi_frame_if.link bus
);
	import status_pkg::*;

	logic [5:0] bit_cnt_q;
	logic [ADDR_W-1:0] addr_q;
	logic status_rd_q;
	logic done_q;
	logic [DATA_W-1:0] out_q;
	phase_t phase_q;

	// edge count and phase, cleared by the frame select
	always_ff @(posedge sclk or posedge csb_n)
	begin
		if (csb_n)
		begin
			bit_cnt_q <= CNT_ZERO;
			phase_q <= PH_CMD;
		end
		else
		begin
			if (phase_q != PH_DONE)
				bit_cnt_q <= bit_cnt_q + CNT_ONE;
			case (phase_q)
				PH_CMD: if (bit_cnt_q == CMD_LAST) phase_q <= PH_DATA;
				PH_DATA: if (bit_cnt_q == FRAME_LAST) phase_q <= PH_DONE;
				PH_DONE: phase_q <= PH_DONE;
				default: phase_q <= PH_CMD;
			endcase
		end
	end

	// address shift and read decode; writes never raise any event
	always_ff @(posedge sclk or posedge csb_n)
	begin
		if (csb_n)
		begin
			addr_q <= NULL_LOW_ADDR;
			status_rd_q <= 1'b0;
		end
		else if (phase_q == PH_CMD)
		begin
			addr_q <= {addr_q[ADDR_W-2:0], sdi};
			if (bit_cnt_q == CMD_LAST)
				status_rd_q <= (addr_q == STATUS_ADDR) && sdi;
		end
	end

	// read-clear level, raised on the 32nd edge, dropped at next frame
	always_ff @(posedge sclk or posedge rst)
	begin
		if (rst)
			done_q <= 1'b0;
		else if (bit_cnt_q == CNT_ZERO && phase_q == PH_CMD)
			done_q <= 1'b0;
		else if (status_rd_q && bit_cnt_q == FRAME_LAST)
			done_q <= 1'b1;
	end

	// serial out on falling edges; null or unmapped reads give zeros
	always_ff @(negedge sclk or posedge csb_n)
	begin
		if (csb_n)
			out_q <= STATUS_RESET;
		else if (bit_cnt_q == DATA_FIRST)
			out_q <= status_rd_q ? bus.status_word : STATUS_RESET;
		else
			out_q <= {out_q[DATA_W-2:0], 1'b0};
	end

	assign sdo = out_q[DATA_W-1];
	assign bus.read_done = done_q;
endmodule // spi_link

// *** rtl/status_flags.sv ***
`timescale 1ns/1ps
module status_flags
#(
	parameter int unsigned CNT_W = 32,
	parameter int unsigned DCLOFF_CNT = status_pkg::DCLOFF_CYCLES,
	parameter int unsigned OVER_CNT = status_pkg::OVER_CYCLES,
	parameter int unsigned UNDER_CNT = status_pkg::UNDER_CYCLES,
	parameter int unsigned DRIVE_CNT = status_pkg::DRIVE_CYCLES,
	parameter int unsigned SYNC_HOLD_CNT = status_pkg::SYNC_HOLD_CYCLES
)
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	input wire logic sclk,
	input wire logic csb_n,
	input wire logic sdi,
	output logic sdo,
	output logic sdo_oe,
	input wire logic dcloff_cond,
	input wire logic [3:0] ldoff_detail,
	input wire logic [7:0] magnitude,
	input wire logic [7:0] high_magnitude_threshold,
	input wire logic [7:0] low_magnitude_threshold,
	input wire logic drive_pos_cond,
	input wire logic drive_neg_cond,
	input wire logic [3:0] unread_count,
	input wire logic [2:0] fifo_irq_threshold,
	input wire logic fifo_overflow_evt,
	input wire logic fifo_reset_cmd,
	input wire logic resync_command,
	input wire logic [1:0] lowpower_leadson_select,
	input wire logic leadson_select_wr,
	input wire logic leads_on_cond,
	input wire logic rate_tick,
	input wire logic [1:0] sync_pulse_divider,
	input wire logic sync_pulse_clear_mode,
	input wire logic pll_unlock_cond,
	input wire logic channel_enable,
	input wire logic [status_pkg::IRQ_W-1:0] primary_irq_enable_mask,
	input wire logic [status_pkg::IRQ_W-1:0] secondary_irq_enable_mask,
	output logic primary_irq_pin_n,
	output logic secondary_irq_pin_n,
	output logic [status_pkg::DATA_W-1:0] status_flags_out
);
	import status_pkg::*;

	localparam int NCOND = 5;
	localparam int unsigned LIMITS [NCOND] = '{DCLOFF_CNT, OVER_CNT, UNDER_CNT,
		DRIVE_CNT, DRIVE_CNT};

	// parameter sanity
	if (CNT_W < 2 || CNT_W > 32)
	begin : g_bad_width
		$error("counter width out of range");
	end
	if (DCLOFF_CNT < 1 || OVER_CNT < 1 || UNDER_CNT < 1 || DRIVE_CNT < 1)
	begin : g_bad_count
		$error("persistence count must be at least one");
	end
	if (SYNC_HOLD_CNT < 1 || (CNT_W < 32 && SYNC_HOLD_CNT >= (1 << CNT_W)))
	begin : g_bad_hold
		$error("sync hold count does not fit counter");
	end

	spi_frame_if frame_if ();

	logic [2:0] csb_sync_q;
	logic [2:0] done_sync_q;
	logic csb_lvl_q;
	logic done_lvl_q;
	logic rd_clr;
	logic [NCOND-1:0] cond;
	logic [NCOND-1:0] done;
	logic dcloff_q;
	logic [3:0] ldoff_q;
	logic fifo_thr_q;
	logic fifo_ovf_q;
	logic over_q;
	logic under_q;
	logic drv_mon_q;
	logic drv_pos_q;
	logic drv_neg_q;
	logic leads_on_q;
	logic armed_q;
	logic sync_q;
	logic [3:0] div_cnt_q;
	logic [3:0] div_last;
	logic [CNT_W-1:0] hold_cnt_q;
	logic pll_q;
	logic leadson_force;
	logic [DATA_W-1:0] status_now;
	logic [DATA_W-1:0] word_hold_q;
	logic [DATA_W-1:0] status_out_q;
	logic pri_n_q;
	logic sec_n_q;

	// serial side, clocked by the host's clock
	spi_link u_link
	(
		.sclk(sclk),
		.rst(rst),
		.csb_n(csb_n),
		.sdi(sdi),
		.sdo(sdo),
		.bus(frame_if.link)
	);

	assign sdo_oe = ~csb_n;

	// pin synchronisers for frame select and read-clear level
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			csb_sync_q <= 3'h7;
			done_sync_q <= 3'h0;
		end
		else if (ce)
		begin
			csb_sync_q <= {csb_sync_q[1:0], csb_n};
			done_sync_q <= {done_sync_q[1:0], frame_if.read_done};
		end
	end

	// accept a level once stages two and three agree
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			csb_lvl_q <= 1'b1;
			done_lvl_q <= 1'b0;
		end
		else if (ce)
		begin
			if (csb_sync_q[1] == csb_sync_q[2])
				csb_lvl_q <= csb_sync_q[2];
			if (done_sync_q[1] == done_sync_q[2])
				done_lvl_q <= done_sync_q[2];
		end
	end

	// one-cycle clear pulse on a completed status read
	assign rd_clr = ce && (done_sync_q[1] == done_sync_q[2]) && done_sync_q[2]
		&& !done_lvl_q;

	// detector conditions feeding the persistence timers
	assign cond[0] = dcloff_cond;
	assign cond[1] = magnitude > high_magnitude_threshold;
	assign cond[2] = magnitude <= low_magnitude_threshold;
	assign cond[3] = drive_pos_cond;
	assign cond[4] = drive_neg_cond;

	// persistence timers: count while condition holds, saturate at limit
	for (genvar i = 0; i < NCOND; i++)
	begin : g_persist
		logic [CNT_W-1:0] cnt_q;
		localparam logic [CNT_W-1:0] LIM = CNT_W'(LIMITS[i]);
		always_ff @(posedge mclk)
		begin
			if (rst)
				cnt_q <= '0;
			else if (ce)
			begin
				if (!cond[i])
					cnt_q <= '0;
				else if (cnt_q != LIM)
					cnt_q <= cnt_q + 1'b1;
			end
		end
		assign done[i] = cond[i] && (cnt_q == LIM);
	end

	// dc leads-off flag and its input threshold details
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			dcloff_q <= 1'b0;
			ldoff_q <= 4'h0;
		end
		else if (ce)
		begin
			dcloff_q <= done[0] | (dcloff_q & ~rd_clr);
			ldoff_q <= (done[0] ? ldoff_detail : 4'h0) | (ldoff_q & ~{4{rd_clr}});
		end
	end

	// fifo threshold level: unread records at least field plus one
	always_ff @(posedge mclk)
	begin
		if (rst)
			fifo_thr_q <= 1'b0;
		else if (ce)
			fifo_thr_q <= unread_count >= ({1'b0, fifo_irq_threshold} + 4'h1);
	end

	// fifo overflow held until fifo reset or resync; set wins
	always_ff @(posedge mclk)
	begin
		if (rst)
			fifo_ovf_q <= 1'b0;
		else if (ce)
			fifo_ovf_q <= fifo_overflow_evt |
				(fifo_ovf_q & ~(fifo_reset_cmd | resync_command));
	end

	// magnitude range flags
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			over_q <= 1'b0;
			under_q <= 1'b0;
		end
		else if (ce)
		begin
			over_q <= done[1] | (over_q & ~rd_clr);
			under_q <= done[2] | (under_q & ~rd_clr);
		end
	end

	// drive generator monitor and per-generator details
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			drv_mon_q <= 1'b0;
			drv_pos_q <= 1'b0;
			drv_neg_q <= 1'b0;
		end
		else if (ce)
		begin
			drv_mon_q <= done[3] | done[4] | (drv_mon_q & ~rd_clr);
			drv_pos_q <= done[3] | (drv_pos_q & ~rd_clr);
			drv_neg_q <= done[4] | (drv_neg_q & ~rd_clr);
		end
	end

	// select write with an active low-power mode forces leads-on
	assign leadson_force = leadson_select_wr &&
		(lowpower_leadson_select == LEADSON_SEL_A ||
		lowpower_leadson_select == LEADSON_SEL_B);

	// leads-on arming: any select write disarms, a status read arms
	always_ff @(posedge mclk)
	begin
		if (rst)
			armed_q <= 1'b0;
		else if (ce)
		begin
			if (leadson_select_wr)
				armed_q <= 1'b0;
			else if (rd_clr)
				armed_q <= 1'b1;
		end
	end

	// leads-on sticky flag
	always_ff @(posedge mclk)
	begin
		if (rst)
			leads_on_q <= 1'b0;
		else if (ce)
			leads_on_q <= leadson_force | (armed_q & leads_on_cond &
				(lowpower_leadson_select == LEADSON_SEL_A ||
				lowpower_leadson_select == LEADSON_SEL_B)) |
				(leads_on_q & ~rd_clr);
	end

	// sample divider terminal count
	always_comb
	begin
		case (sync_pulse_divider)
			DIV_EVERY1: div_last = LAST_EVERY1;
			DIV_EVERY2: div_last = LAST_EVERY2;
			DIV_EVERY4: div_last = LAST_EVERY4;
			default: div_last = LAST_EVERY16;
		endcase
	end

	// sample divider counter, restarted by resync
	always_ff @(posedge mclk)
	begin
		if (rst)
			div_cnt_q <= 4'h0;
		else if (ce)
		begin
			if (resync_command)
				div_cnt_q <= 4'h0;
			else if (rate_tick)
				div_cnt_q <= (div_cnt_q >= div_last) ? 4'h0 : div_cnt_q + 4'h1;
		end
	end

	// sync flag: self-clearing after hold time, or cleared by status read
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			sync_q <= 1'b0;
			hold_cnt_q <= '0;
		end
		else if (ce)
		begin
			if (rate_tick && !resync_command && div_cnt_q >= div_last)
			begin
				sync_q <= 1'b1;
				hold_cnt_q <= CNT_W'(SYNC_HOLD_CNT);
			end
			else if (sync_pulse_clear_mode == SYNC_SELF_CLEAR)
			begin
				if (hold_cnt_q != '0)
					hold_cnt_q <= hold_cnt_q - 1'b1;
				if (hold_cnt_q <= {{(CNT_W-1){1'b0}}, 1'b1})
					sync_q <= 1'b0;
			end
			else if (rd_clr)
				sync_q <= 1'b0;
		end
	end

	// pll unlock flag, only while the channel is powered
	always_ff @(posedge mclk)
	begin
		if (rst)
			pll_q <= 1'b0;
		else if (ce)
			pll_q <= channel_enable & (pll_unlock_cond | (pll_q & ~rd_clr));
	end

	// status word assembly, unassigned positions zero
	always_comb
	begin
		status_now = STATUS_RESET;
		status_now[DCLOFF_BIT] = dcloff_q;
		status_now[FIFO_THR_BIT] = fifo_thr_q;
		status_now[FIFO_OVF_BIT] = fifo_ovf_q;
		status_now[OVER_BIT] = over_q;
		status_now[UNDER_BIT] = under_q;
		status_now[DRV_MON_BIT] = drv_mon_q;
		status_now[LEADS_ON_BIT] = leads_on_q;
		status_now[SYNC_BIT] = sync_q;
		status_now[PLL_BIT] = pll_q;
		status_now[DRV_POS_BIT] = drv_pos_q;
		status_now[DRV_NEG_BIT] = drv_neg_q;
		status_now[LDOFF_LSB +: 4] = ldoff_q;
		status_now = status_now & FLAG_MASK;
	end

	// read snapshot, frozen while a frame is open so the link sees a stable word
	always_ff @(posedge mclk)
	begin
		if (rst)
			word_hold_q <= STATUS_RESET;
		else if (ce && csb_lvl_q && csb_sync_q[1] && csb_sync_q[2])
			word_hold_q <= status_now;
	end

	assign frame_if.status_word = word_hold_q;

	// observation copy of the flags
	always_ff @(posedge mclk)
	begin
		if (rst)
			status_out_q <= STATUS_RESET;
		else if (ce)
			status_out_q <= status_now;
	end

	assign status_flags_out = status_out_q;

	// interrupt pins, active low, OR of enabled flags
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			pri_n_q <= 1'b1;
			sec_n_q <= 1'b1;
		end
		else if (ce)
		begin
			pri_n_q <= ~|(status_now[IRQ_LSB +: IRQ_W] & primary_irq_enable_mask &
				FLAG_MASK[IRQ_LSB +: IRQ_W]);
			sec_n_q <= ~|(status_now[IRQ_LSB +: IRQ_W] & secondary_irq_enable_mask &
				FLAG_MASK[IRQ_LSB +: IRQ_W]);
		end
	end

	assign primary_irq_pin_n = pri_n_q;
	assign secondary_irq_pin_n = sec_n_q;
endmodule // status_flags

// *** sim/spi_host.sv ***
`timescale 1ns/1ps
module spi_host
(
	output logic sclk,
	output logic csb_n,
	output logic sdi,
	input wire logic sdo
);
	// frame select idle high, serial clock parked low between frames
	initial
	begin
		sclk = 1'b0;
		csb_n = 1'b0;
		sdi = 1'b0;
		#1 csb_n = 1'b1; // a clean rising edge clears the link counters
	end
	// one 32-edge frame, msb first; read data taken on rising edges
	task automatic xfer(input logic [7:0] cmd, input logic [23:0] wd, output logic [23:0] rd);
		logic [31:0] sh;
		sh = {cmd, wd};
		rd = 24'h000000;
		#37.3 csb_n = 1'b0;
		for (int i = 0; i < 32; i++)
		begin
			sdi = sh[31 - i];
			#80 sclk = 1'b1;
			if (i >= 8)
				rd = {rd[22:0], sdo};
			#80 sclk = 1'b0;
		end
		#40 csb_n = 1'b1;
		sdi = ~sdi; // released line shows no stale value
		#200;
	endtask
endmodule // spi_host

// *** sim/status_flags_assertions.sv ***
`timescale 1ns/1ps
module status_flags_assertions
#(
	parameter int unsigned OVER_CNT = 6
)
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic csb_n,
	input wire logic sdo_oe,
	input wire logic [7:0] magnitude,
	input wire logic [7:0] high_magnitude_threshold,
	input wire logic [3:0] unread_count,
	input wire logic [2:0] fifo_irq_threshold,
	input wire logic fifo_reset_cmd,
	input wire logic resync_command,
	input wire logic channel_enable,
	input wire logic [status_pkg::IRQ_W-1:0] primary_irq_enable_mask,
	input wire logic [status_pkg::IRQ_W-1:0] secondary_irq_enable_mask,
	input wire logic primary_irq_pin_n,
	input wire logic secondary_irq_pin_n,
	input wire logic [status_pkg::DATA_W-1:0] status_flags_out
);
	import status_pkg::*;
	logic [1:0] run_q;
	logic clr_cmd;
	int unsigned over_q;
	default clocking @(posedge mclk);
	endclocking
	default disable iff (rst);
	// edges since reset release, saturating
	always_ff @(posedge mclk)
	begin
		if (rst)
			run_q <= 2'h0;
		else if (run_q != 2'h3)
			run_q <= run_q + 2'h1;
	end
	// consecutive cycles above the high threshold
	always_ff @(posedge mclk)
	begin
		if (rst || magnitude <= high_magnitude_threshold)
			over_q <= 0;
		else if (over_q < OVER_CNT)
			over_q <= over_q + 1;
	end
	assign clr_cmd = fifo_reset_cmd | resync_command;
	// steps of power-down and of overflow clearing
	sequence chan_off;
		!channel_enable [*3];
	endsequence
	sequence ovf_clear_seen;
		$past(clr_cmd, 2) || $past(clr_cmd, 3);
	endsequence
	sdo_enable_a: assert property (sdo_oe == !csb_n)
		else $error("sdo enable differs from frame select");
	spare_bits_a: assert property ((status_flags_out & ~FLAG_MASK) == 24'h000000)
		else $error("unassigned status bit set");
	irq_or_a: assert property (run_q == 2'h3 |->
		primary_irq_pin_n == !(|(status_flags_out[23:8] & $past(primary_irq_enable_mask)))
		&& secondary_irq_pin_n == !(|(status_flags_out[23:8] & $past(secondary_irq_enable_mask))))
		else $error("irq pin not the masked or of flags");
	fifo_level_a: assert property (run_q == 2'h3 |-> status_flags_out[FIFO_THR_BIT] ==
		($past(unread_count, 2) > {1'b0, $past(fifo_irq_threshold, 2)}))
		else $error("fifo threshold flag wrong");
	ovf_hold_a: assert property (run_q == 2'h3 && $fell(status_flags_out[FIFO_OVF_BIT])
		|-> ovf_clear_seen) else $error("overflow flag dropped without clear command");
	pll_power_a: assert property (chan_off |-> !status_flags_out[PLL_BIT])
		else $error("pll flag while channel off");
	ldoff_detail_a: assert property (|status_flags_out[3:0] |-> status_flags_out[DCLOFF_BIT])
		else $error("input detail without leads-off flag");
	drive_detail_a: assert property (status_flags_out[DRV_POS_BIT]
		|| status_flags_out[DRV_NEG_BIT] |-> status_flags_out[DRV_MON_BIT])
		else $error("drive detail without drive monitor flag");
	over_persist_a: assert property (over_q == OVER_CNT |-> ##[0:3] status_flags_out[OVER_BIT])
		else $error("over-range flag late");
endmodule // status_flags_assertions

// *** sim/status_flags_bench.sv ***
`timescale 1ns/1ps
module status_flags_bench;
	import status_pkg::*;
	logic mclk, rst = 1'b1, sclk, csb_n, sdi, sdo, sdo_oe, primary_irq_pin_n, secondary_irq_pin_n;
	logic dcloff_cond = 1'b0, drive_pos_cond = 1'b0, drive_neg_cond = 1'b0, leads_on_cond = 1'b0;
	logic fifo_overflow_evt = 1'b0, fifo_reset_cmd = 1'b0, resync_command = 1'b0;
	logic leadson_select_wr = 1'b0, rate_tick = 1'b0, pll_unlock_cond = 1'b0;
	logic channel_enable = 1'b0, sync_pulse_clear_mode = 1'b1;
	logic ce = 1'b1;
	logic [3:0] ldoff_detail = 4'h0, unread_count = 4'h0;
	logic [7:0] magnitude = 8'h40, high_magnitude_threshold = 8'hC0, low_magnitude_threshold = 8'h10;
	logic [2:0] fifo_irq_threshold = 3'h3;
	logic [1:0] lowpower_leadson_select = 2'h0, sync_pulse_divider = 2'h0;
	logic [15:0] primary_irq_enable_mask = 16'h0400, secondary_irq_enable_mask = 16'h0100;
	logic [23:0] status_flags_out, v;
	int bad_count = 0, check_count = 0;
	status_flags #(.DCLOFF_CNT(5), .OVER_CNT(6), .UNDER_CNT(7), .DRIVE_CNT(8), .SYNC_HOLD_CNT(4))
		i_status_flags (.*);
	spi_host i_spi_host (.*);
	// core clock
	initial
	begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	task automatic conclude();
		if (bad_count == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
		check_count++;
		if (got !== exp)
		begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge mclk);
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		cyc(1);
		s = 1'b0;
	endtask
	task automatic rd(input logic [6:0] a);
		i_spi_host.xfer({a, 1'b1}, 24'h000000, v);
		cyc(2);
	endtask
	task automatic t_ovf_null();
		logic [6:0] al [3] = '{NULL_LOW_ADDR, NULL_HIGH_ADDR, 7'h05};
		pulse(fifo_overflow_evt);
		cyc(3);
		chk("overflow", 24'h040000, status_flags_out);
		chk("pins", 24'h000001, {22'h0, primary_irq_pin_n, secondary_irq_pin_n});
		for (int i = 0; i < 3; i++)
		begin
			i_spi_host.xfer({al[i], 1'b0}, 24'hFFFFFF, v);
			rd(al[i]);
			chk("null read", 24'h000000, v);
		end
		rd(STATUS_ADDR);
		chk("overflow read", 24'h040000, v);
		chk("overflow kept", 24'h040000, status_flags_out);
		pulse(fifo_reset_cmd);
		cyc(3);
		chk("overflow reset", 24'h000000, status_flags_out);
		pulse(fifo_overflow_evt);
		pulse(resync_command);
		cyc(3);
		chk("overflow resync", 24'h000000, status_flags_out);
	endtask
	task automatic t_dcloff();
		ldoff_detail = 4'hA;
		dcloff_cond = 1'b1;
		cyc(4);
		chk("dcloff early", 24'h000000, status_flags_out);
		cyc(6);
		rd(STATUS_ADDR);
		chk("dcloff read", 24'h10000A, v);
		chk("dcloff persists", 24'h10000A, status_flags_out);
		dcloff_cond = 1'b0;
		ldoff_detail = 4'h0;
		cyc(3);
		chk("dcloff latched", 24'h10000A, status_flags_out);
		rd(STATUS_ADDR);
		chk("dcloff cleared", 24'h000000, status_flags_out);
	endtask
	task automatic t_ranges();
		magnitude = 8'hD0;
		drive_pos_cond = 1'b1;
		cyc(14);
		chk("over drive", 24'h028020, status_flags_out);
		magnitude = 8'h08;
		drive_pos_cond = 1'b0;
		drive_neg_cond = 1'b1;
		cyc(14);
		chk("under drive", 24'h038030, status_flags_out);
		magnitude = 8'h40;
		drive_neg_cond = 1'b0;
		rd(STATUS_ADDR);
		rd(STATUS_ADDR);
		chk("ranges cleared", 24'h000000, v);
	endtask
	task automatic t_fifo();
		for (int t = 0; t < 8; t++)
		begin
			fifo_irq_threshold = 3'(t);
			unread_count = 4'(t);
			cyc(3);
			chk("fifo below", 24'h000000, status_flags_out);
			unread_count = 4'(t + 1);
			cyc(3);
			chk("fifo at", 24'h080000, status_flags_out);
		end
		unread_count = 4'h0;
	endtask
	task automatic t_leads();
		for (int m = 1; m < 3; m++)
		begin
			lowpower_leadson_select = 2'(m);
			pulse(leadson_select_wr);
			cyc(2);
			chk("leads-on forced", 24'h000800, status_flags_out);
			rd(STATUS_ADDR);
			chk("leads-on armed", 24'h000000, status_flags_out);
			pulse(leads_on_cond);
			cyc(3);
			chk("leads-on seen", 24'h000800, status_flags_out);
			rd(STATUS_ADDR);
		end
		lowpower_leadson_select = 2'h0;
	endtask
	task automatic t_sync();
		int ex [4] = '{1, 2, 4, 16};
		int n;
		for (int d = 0; d < 4; d++)
		begin
			sync_pulse_divider = 2'(d);
			pulse(resync_command);
			n = 0;
			do
			begin
				pulse(rate_tick);
				cyc(2);
				n++;
			end while (status_flags_out[SYNC_BIT] !== 1'b1 && n < 20);
			chk("sync spacing", 24'(ex[d]), 24'(n));
			if (n >= 20)
				conclude();
			cyc(8);
			chk("sync self clear", 24'h000000, status_flags_out);
		end
		sync_pulse_divider = 2'h0;
		sync_pulse_clear_mode = 1'b0;
		pulse(rate_tick);
		cyc(10);
		chk("sync held", 24'h000200, status_flags_out);
		rd(STATUS_ADDR);
		chk("sync read clear", 24'h000000, status_flags_out);
	endtask
	task automatic t_pll();
		pll_unlock_cond = 1'b1;
		secondary_irq_enable_mask = 16'h0001;
		cyc(4);
		chk("pll off", 24'h000000, status_flags_out);
		channel_enable = 1'b1;
		cyc(3);
		chk("pll unlocked", 24'h000100, status_flags_out);
		chk("pins", 24'h000002, {22'h0, primary_irq_pin_n, secondary_irq_pin_n});
		pll_unlock_cond = 1'b0;
		channel_enable = 1'b0;
		cyc(3);
		chk("pll down", 24'h000000, status_flags_out);
	endtask
	// an event while the clock enable is low must be lost
	task automatic t_freeze();
		ce = 1'b0;
		pulse(fifo_overflow_evt);
		cyc(3);
		ce = 1'b1;
		cyc(3);
		chk("frozen overflow", 24'h000000, status_flags_out);
	endtask
	// reset, then every scenario in turn
	initial
	begin
		cyc(3);
		rst = 1'b0;
		cyc(5);
		chk("reset status", STATUS_RESET, status_flags_out);
		chk("reset pins", 24'h000003, {22'h0, primary_irq_pin_n, secondary_irq_pin_n});
		t_ovf_null();
		t_dcloff();
		t_ranges();
		t_fifo();
		t_leads();
		t_sync();
		t_pll();
		t_freeze();
		conclude();
	end
endmodule // status_flags_bench
bind status_flags status_flags_assertions #(.OVER_CNT(OVER_CNT)) i_status_flags_assertions (.*);
